// [core/gp_pkg.sv]
package gp_pkg;
  localparam int NPA = 4;
  localparam int NPB = 8;
  localparam int NPIN = NPA + NPB;
  localparam int AW = 5;
  localparam int DW = 8;
  // Register offsets
  localparam logic [AW-1:0] OFF_DATA_A = 5'h00;
  localparam logic [AW-1:0] OFF_DATA_B = 5'h01;
  localparam logic [AW-1:0] OFF_DIR_A = 5'h02;
  localparam logic [AW-1:0] OFF_DIR_B = 5'h03;
  localparam logic [AW-1:0] OFF_PULL_LOW = 5'h04;
  localparam logic [AW-1:0] OFF_PULL_HIGH = 5'h05;
  localparam logic [AW-1:0] OFF_OPEN_DRAIN = 5'h06;
  localparam logic [AW-1:0] OFF_CHG_SEL = 5'h07;
  localparam logic [AW-1:0] OFF_INT_FLAG = 5'h08;
  localparam logic [AW-1:0] OFF_INT_EN = 5'h09;
  localparam logic [AW-1:0] OFF_PWR_CTL = 5'h0a;
  localparam logic [AW-1:0] OFF_PWR_CTL1 = 5'h0b;
  localparam logic [AW-1:0] OFF_IR_CTL = 5'h0c;
  localparam logic [AW-1:0] OFF_T1_CTL1 = 5'h0d;
  localparam logic [AW-1:0] OFF_BZ_CTL = 5'h0e;
  localparam logic [AW-1:0] OFF_MISC = 5'h0f;
  localparam logic [AW-1:0] OFF_RD_TYPE_A = 5'h10;
  localparam logic [AW-1:0] OFF_RD_TYPE_B = 5'h11;
  // Field positions
  localparam int BIT_PORT_CHG = 1;
  localparam int BIT_EXT_INT = 2;
  localparam int BIT_EXT_SEL = 6;
  localparam int BIT_GLOBAL_EN = 7;
  localparam int BIT_IR_EN = 0;
  localparam int BIT_PWM_EN = 7;
  localparam int BIT_BZ_EN = 7;
  localparam int BIT_EDGE_RISE = 0;
  localparam int BIT_T0_SRC = 1;
  localparam int BIT_T0_LOW = 2;
  localparam int BIT_T1_SRC = 3;
  // Pin indices in the 12-bit pad vector
  localparam int PB0 = 4;
  localparam int PB1 = 5;
  localparam int PB2 = 6;
  localparam int PB3 = 7;
  localparam int PB4 = 8;
  localparam int PB5 = 9;
  localparam int PB6 = 10;
  localparam int PB7 = 11;
  // Reset values and the pull-high capability mask
  localparam logic [DW-1:0] RST_ZERO = 8'h00;
  localparam logic [DW-1:0] RST_DIR = 8'hff;
  localparam logic [DW-1:0] PH_CAPABLE = 8'hf7;
  typedef struct packed {
    logic [NPIN-1:0] out;
    logic [NPIN-1:0] oe;
    logic [NPIN-1:0] pu;
    logic [NPIN-1:0] pd;
  } gp_pad_t;
  typedef struct packed {
    logic t0_clk;
    logic t1_clk;
    logic ext_rst;
    logic int_req;
  } gp_evt_t;
endpackage

// [core/gp_port.sv]
`timescale 1ns/100ps
// How it works
// - Twelve pins, four on port A, eight on port B, one data bit each.
// - A direction bit per pin chooses input or output, 4 for A, 8 for B.
// - Pulls act only on inputs; pull-low bits 3..0 serve port A.
// - Pull-high bits serve port B 7..4 and 2..0; PB3 and port A have none.
// - Pull-low bits 7..4 serve port B 3..0; port B 7..4 have none.
// - Port B outputs pick open-drain or push-pull per bit; port A push-pull.
// - PB3 as output always drives open-drain.
// - A level change on a selected port B pin sets the port-change flag.
// - Port-change request needs flag, its enable and global enable.
// - External-interrupt select makes PB0 the external interrupt input.
// - With PB0 as external interrupt its change detection is suppressed.
// - IR carrier enable drives the carrier onto PB1.
// - PB3 as reset pin: low level requests device reset.
// - Crystal option takes PB5 as crystal input, PB4 as output.
// - Clock-out option without crystal drives instruction clock on PB4.
// - PB2 feeds the external count clock to timer 0 or timer 1.
// - PWM enable drives PB6, buzzer enable drives PB7.
// - Each pin read returns pad level or output latch, per selector.
// - IR enabled forces PB1 to output; disabled restores general I/O.
// - PWM enabled forces PB6 to output regardless of direction.
module gp_port
  import gp_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DW-1:0] rdata,
  input wire logic [NPIN-1:0] pad_i,
  output gp_pad_t pad,
  output gp_evt_t evt,
  input wire logic cfg_pb3_reset,
  input wire logic cfg_xtal_en,
  input wire logic cfg_clkout_en,
  input wire logic ir_carrier,
  input wire logic inst_clk,
  input wire logic pwm_data,
  input wire logic bz_data
);
  logic [NPA-1:0] data_a_r, dir_a_r, rdt_a_r;
  logic [NPB-1:0] data_b_r, dir_b_r, rdt_b_r;
  logic [DW-1:0] pull_low_r, pull_high_r, open_drain_r, chg_sel_r;
  logic [DW-1:0] int_flag_r, int_en_r, pwr_r, pwr1_r, ir_r, t1c_r, bz_r, misc_r;
  logic [NPIN-1:0] sync1_r, sync2_r, prev_r;
  logic [DW-1:0] rdata_nxt;
  gp_pad_t pad_nxt;
  gp_evt_t evt_nxt;
  logic [NPB-1:0] chg_hit;
  logic ext_hit, flag_clr_pc, flag_clr_ext;
  logic [NPIN-1:0] level;
  logic [2:0] warm_r;

  function automatic logic wr_to(input logic [AW-1:0] off);
    wr_to = wr && (addr == off);
  endfunction

  // Pad inputs are asynchronous; two stages before use
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
      warm_r <= 3'h0;
    end else if (ce) begin
      sync1_r <= pad_i;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      // Stages hold reset zeros for three edges; a pin idling high would fake a change
      warm_r <= {warm_r[1:0], 1'b1};
    end
  end

  // Control registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      data_a_r <= RST_ZERO[NPA-1:0];
      data_b_r <= RST_ZERO;
      dir_a_r <= RST_DIR[NPA-1:0];
      dir_b_r <= RST_DIR;
      rdt_a_r <= RST_ZERO[NPA-1:0];
      rdt_b_r <= RST_ZERO;
      pull_low_r <= RST_ZERO;
      pull_high_r <= RST_ZERO;
      open_drain_r <= RST_ZERO;
      chg_sel_r <= RST_ZERO;
      int_en_r <= RST_ZERO;
      pwr_r <= RST_ZERO;
      pwr1_r <= RST_ZERO;
      ir_r <= RST_ZERO;
      t1c_r <= RST_ZERO;
      bz_r <= RST_ZERO;
      misc_r <= RST_ZERO;
    end else if (ce) begin
      if (wr_to(OFF_DATA_A)) data_a_r <= wdata[NPA-1:0];
      if (wr_to(OFF_DATA_B)) data_b_r <= wdata;
      if (wr_to(OFF_DIR_A)) dir_a_r <= wdata[NPA-1:0];
      if (wr_to(OFF_DIR_B)) dir_b_r <= wdata;
      if (wr_to(OFF_RD_TYPE_A)) rdt_a_r <= wdata[NPA-1:0];
      if (wr_to(OFF_RD_TYPE_B)) rdt_b_r <= wdata;
      if (wr_to(OFF_PULL_LOW)) pull_low_r <= wdata;
      // PB3 has no pull-high, so its bit stays zero
      if (wr_to(OFF_PULL_HIGH)) pull_high_r <= wdata & PH_CAPABLE;
      if (wr_to(OFF_OPEN_DRAIN)) open_drain_r <= wdata;
      if (wr_to(OFF_CHG_SEL)) chg_sel_r <= wdata;
      if (wr_to(OFF_INT_EN)) int_en_r <= wdata;
      if (wr_to(OFF_PWR_CTL)) pwr_r <= wdata;
      if (wr_to(OFF_PWR_CTL1)) pwr1_r <= wdata;
      if (wr_to(OFF_IR_CTL)) ir_r <= wdata;
      if (wr_to(OFF_T1_CTL1)) t1c_r <= wdata;
      if (wr_to(OFF_BZ_CTL)) bz_r <= wdata;
      if (wr_to(OFF_MISC)) misc_r <= wdata;
    end
  end

  // Change and edge detection
  always_comb begin
    chg_hit = (sync2_r[NPIN-1:NPA] ^ prev_r[NPIN-1:NPA]) & chg_sel_r;
    if (pwr_r[BIT_EXT_SEL]) begin
      chg_hit[0] = 1'b0;
    end
    if (misc_r[BIT_EDGE_RISE]) begin
      ext_hit = pwr_r[BIT_EXT_SEL] && sync2_r[PB0] && !prev_r[PB0];
    end else begin
      ext_hit = pwr_r[BIT_EXT_SEL] && !sync2_r[PB0] && prev_r[PB0];
    end
    flag_clr_pc = wr_to(OFF_INT_FLAG) && !wdata[BIT_PORT_CHG];
    flag_clr_ext = wr_to(OFF_INT_FLAG) && !wdata[BIT_EXT_INT];
    if (!warm_r[2]) begin
      chg_hit = '0;
      ext_hit = 1'b0;
    end
  end

  // Sticky flags; a new event wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      int_flag_r <= RST_ZERO;
    end else if (ce) begin
      if (|chg_hit) begin
        int_flag_r[BIT_PORT_CHG] <= 1'b1;
      end else if (flag_clr_pc) begin
        int_flag_r[BIT_PORT_CHG] <= 1'b0;
      end
      if (ext_hit) begin
        int_flag_r[BIT_EXT_INT] <= 1'b1;
      end else if (flag_clr_ext) begin
        int_flag_r[BIT_EXT_INT] <= 1'b0;
      end
    end
  end

  // Pad drive
  always_comb begin
    pad_nxt = '0;
    level = {data_b_r, data_a_r};
    for (int i = 0; i < NPA; i++) begin
      pad_nxt.oe[i] = !dir_a_r[i];
      pad_nxt.out[i] = data_a_r[i];
      pad_nxt.pd[i] = dir_a_r[i] && pull_low_r[i];
    end
    for (int i = 0; i < NPB; i++) begin
      pad_nxt.out[NPA+i] = level[NPA+i];
      // Open-drain only drives the low level
      if (open_drain_r[i] || (i == 3)) begin
        pad_nxt.oe[NPA+i] = !dir_b_r[i] && !level[NPA+i];
      end else begin
        pad_nxt.oe[NPA+i] = !dir_b_r[i];
      end
      pad_nxt.pu[NPA+i] = dir_b_r[i] && pull_high_r[i];
      if (i < 4) begin
        pad_nxt.pd[NPA+i] = dir_b_r[i] && pull_low_r[4+i];
      end
    end
    if (ir_r[BIT_IR_EN]) begin
      pad_nxt.out[PB1] = ir_carrier;
      pad_nxt.oe[PB1] = 1'b1;
      pad_nxt.pu[PB1] = 1'b0;
      pad_nxt.pd[PB1] = 1'b0;
    end
    if (cfg_pb3_reset) begin
      pad_nxt.oe[PB3] = 1'b0;
      pad_nxt.pd[PB3] = 1'b0;
    end
    if (cfg_xtal_en) begin
      pad_nxt.oe[PB5:PB4] = 2'b00;
      pad_nxt.pu[PB5:PB4] = 2'b00;
    end else if (cfg_clkout_en) begin
      pad_nxt.out[PB4] = inst_clk;
      pad_nxt.oe[PB4] = 1'b1;
      pad_nxt.pu[PB4] = 1'b0;
    end
    if (t1c_r[BIT_PWM_EN]) begin
      pad_nxt.out[PB6] = pwm_data;
      pad_nxt.oe[PB6] = 1'b1;
      pad_nxt.pu[PB6] = 1'b0;
    end
    if (bz_r[BIT_BZ_EN]) begin
      pad_nxt.out[PB7] = bz_data;
      pad_nxt.oe[PB7] = 1'b1;
      pad_nxt.pu[PB7] = 1'b0;
    end
  end

  // Side events
  always_comb begin
    evt_nxt.t0_clk = misc_r[BIT_T0_SRC] && !misc_r[BIT_T0_LOW] && sync2_r[PB2];
    evt_nxt.t1_clk = misc_r[BIT_T1_SRC] && sync2_r[PB2];
    // A false low straight after reset would restart the device
    evt_nxt.ext_rst = cfg_pb3_reset && warm_r[1] && !sync2_r[PB3];
    evt_nxt.int_req = pwr1_r[BIT_GLOBAL_EN] && ((int_flag_r[BIT_PORT_CHG]
      && int_en_r[BIT_PORT_CHG]) || (int_flag_r[BIT_EXT_INT] && int_en_r[BIT_EXT_INT]));
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    case (addr)
      OFF_DATA_A: rdata_nxt = {4'h0, (rdt_a_r & data_a_r) | (~rdt_a_r & sync2_r[NPA-1:0])};
      OFF_DATA_B: rdata_nxt = (rdt_b_r & data_b_r) | (~rdt_b_r & sync2_r[NPIN-1:NPA]);
      OFF_DIR_A: rdata_nxt = {4'h0, dir_a_r};
      OFF_DIR_B: rdata_nxt = dir_b_r;
      OFF_PULL_LOW: rdata_nxt = pull_low_r;
      OFF_PULL_HIGH: rdata_nxt = pull_high_r;
      OFF_OPEN_DRAIN: rdata_nxt = open_drain_r;
      OFF_CHG_SEL: rdata_nxt = chg_sel_r;
      OFF_INT_FLAG: rdata_nxt = int_flag_r;
      OFF_INT_EN: rdata_nxt = int_en_r;
      OFF_PWR_CTL: rdata_nxt = pwr_r;
      OFF_PWR_CTL1: rdata_nxt = pwr1_r;
      OFF_IR_CTL: rdata_nxt = ir_r;
      OFF_T1_CTL1: rdata_nxt = t1c_r;
      OFF_BZ_CTL: rdata_nxt = bz_r;
      OFF_MISC: rdata_nxt = misc_r;
      OFF_RD_TYPE_A: rdata_nxt = {4'h0, rdt_a_r};
      OFF_RD_TYPE_B: rdata_nxt = rdt_b_r;
      default: rdata_nxt = RST_ZERO;
    endcase
  end

  // All outputs registered
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdata <= RST_ZERO;
      pad <= '0;
      evt <= '0;
    end else if (ce) begin
      if (rd) rdata <= rdata_nxt;
      pad <= pad_nxt;
      evt <= evt_nxt;
    end
  end

  property p_flag_sets;
    @(posedge mclk) disable iff (!rstn)
      ce && (|chg_hit) |=> int_flag_r[BIT_PORT_CHG];
  endproperty
  a_flag_set_event: assert property (p_flag_sets)
    else $error("port change not flagged");

  a_flag_sticky_hold: assert property (@(posedge mclk) disable iff (!rstn)
    ce && int_flag_r[BIT_PORT_CHG] && !flag_clr_pc |=> int_flag_r[BIT_PORT_CHG])
    else $error("port change flag dropped");

  a_int_req_gate: assert property (@(posedge mclk) disable iff (!rstn)
    ce && evt_nxt.int_req |=> evt.int_req ##0 pwr1_r[BIT_GLOBAL_EN] || $past(wr))
    else $error("interrupt request without global enable");

  a_pb3_open_drain: assert property (@(posedge mclk) disable iff (!rstn)
    pad.oe[PB3] |-> !pad.out[PB3])
    else $error("pb3 drove high");

  a_pull_input_only: assert property (@(posedge mclk) disable iff (!rstn)
    (pad.pu & pad.oe) == '0 && (pad.pd & pad.oe) == '0)
    else $error("pull on a driven pin");

  a_pull_capability: assert property (@(posedge mclk) disable iff (!rstn)
    pad.pu[NPA-1:0] == 4'h0 && !pad.pu[PB3]
      && pad.pd[PB7:PB4] == 4'h0)
    else $error("pull on an incapable pin");

  sequence s_only_pb0_change;
    ce && pwr_r[BIT_EXT_SEL] && !int_flag_r[BIT_PORT_CHG]
      && ((sync2_r[NPIN-1:NPA] ^ prev_r[NPIN-1:NPA]) == 8'h01);
  endsequence
  a_pb0_chg_block: assert property (@(posedge mclk) disable iff (!rstn)
    s_only_pb0_change |=> !int_flag_r[BIT_PORT_CHG])
    else $error("pb0 change flagged under external interrupt");

  a_pwm_forces_out: assert property (@(posedge mclk) disable iff (!rstn)
    ce && t1c_r[BIT_PWM_EN] |=> pad.oe[PB6] && pad.out[PB6] == $past(pwm_data))
    else $error("pwm pin not driven");

  a_ir_forces_out: assert property (@(posedge mclk) disable iff (!rstn)
    ce && ir_r[BIT_IR_EN] |=> pad.oe[PB1] && pad.out[PB1] == $past(ir_carrier))
    else $error("ir pin not driven");

  a_dir_readback: assert property (@(posedge mclk) disable iff (!rstn)
    ce && rd && addr == OFF_DIR_B |=> rdata == $past(dir_b_r))
    else $error("direction readback wrong");

  a_flag_clear_zero: assert property (@(posedge mclk) disable iff (!rstn)
    ce && flag_clr_pc && !(|chg_hit) |=> !int_flag_r[BIT_PORT_CHG])
    else $error("port change flag not cleared");

  sequence s_pb0_falls;
    ce && warm_r[2] && pwr_r[BIT_EXT_SEL] && !misc_r[BIT_EDGE_RISE]
      && prev_r[PB0] && !sync2_r[PB0];
  endsequence
  sequence s_pb0_rises;
    ce && warm_r[2] && pwr_r[BIT_EXT_SEL] && misc_r[BIT_EDGE_RISE]
      && !prev_r[PB0] && sync2_r[PB0];
  endsequence
  a_ext_edge_flag: assert property (@(posedge mclk) disable iff (!rstn)
    (s_pb0_falls or s_pb0_rises) |=> int_flag_r[BIT_EXT_INT])
    else $error("external edge not flagged");

  a_pa_push_pull: assert property (@(posedge mclk) disable iff (!rstn)
    ce |=> pad.oe[NPA-1:0] == ~$past(dir_a_r))
    else $error("port a drive differs from direction");

  a_reset_pin_free: assert property (@(posedge mclk) disable iff (!rstn)
    ce && cfg_pb3_reset |=> !pad.oe[PB3] && !pad.pd[PB3])
    else $error("reset pin still driven or pulled");

  a_xtal_pins_free: assert property (@(posedge mclk) disable iff (!rstn)
    ce && cfg_xtal_en |=> pad.oe[PB5:PB4] == 2'b00 && pad.pu[PB5:PB4] == 2'b00)
    else $error("crystal pins still driven or pulled");

  a_clkout_drive: assert property (@(posedge mclk) disable iff (!rstn)
    ce && cfg_clkout_en && !cfg_xtal_en |=> pad.oe[PB4] && pad.out[PB4] == $past(inst_clk))
    else $error("clock output not driven");

  a_timer_clk_route: assert property (@(posedge mclk) disable iff (!rstn)
    ce |=> evt.t1_clk == ($past(misc_r[BIT_T1_SRC]) && $past(sync2_r[PB2]))
      && evt.t0_clk == ($past(misc_r[BIT_T0_SRC]) && !$past(misc_r[BIT_T0_LOW])
      && $past(sync2_r[PB2])))
    else $error("timer clock routing wrong");

  a_buzzer_drive: assert property (@(posedge mclk) disable iff (!rstn)
    ce && bz_r[BIT_BZ_EN] |=> pad.oe[PB7] && pad.out[PB7] == $past(bz_data))
    else $error("buzzer pin not driven");

  a_latch_readback: assert property (@(posedge mclk) disable iff (!rstn)
    ce && rd && addr == OFF_DATA_A && rdt_a_r == 4'hf |=> rdata[NPA-1:0] == $past(data_a_r))
    else $error("latch readback wrong");

  a_ce_freeze: assert property (@(posedge mclk) disable iff (!rstn)
    !ce |=> $stable(int_flag_r) && $stable(pad) && $stable(rdata))
    else $error("state moved with clock enable low");
endmodule

// [tb/gp_pins.sv]
`timescale 1ns/100ps
module gp_pins
  import gp_pkg::*;
(
  input wire logic mclk,
  input wire gp_pad_t pad,
  input wire logic [NPIN-1:0] ext_en,
  input wire logic [NPIN-1:0] ext_val,
  output logic [NPIN-1:0] pad_i
);
  // Undriven, unpulled pins wander so a stale level never reads as a drive
  logic flt_r = 1'b0;
  always @(posedge mclk) begin
    flt_r <= ~flt_r;
  end
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (pad.oe[i])
        pad_i[i] = pad.out[i];
      else if (ext_en[i])
        pad_i[i] = ext_val[i];
      else if (pad.pu[i])
        pad_i[i] = 1'b1;
      else if (pad.pd[i])
        pad_i[i] = 1'b0;
      else
        pad_i[i] = flt_r;
    end
  end
endmodule

// [tb/testbench.sv]
`timescale 1ns/100ps
module testbench
  import gp_pkg::*;
;
  logic mclk, rstn, ce, wr, rd;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata, q;
  logic [NPIN-1:0] pad_i, ext_en, ext_val;
  gp_pad_t pad;
  gp_evt_t evt;
  logic cfg_pb3_reset, cfg_xtal_en, cfg_clkout_en;
  logic ir_carrier, inst_clk, pwm_data, bz_data;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  gp_port uut (.mclk, .rstn, .ce, .addr, .wdata, .wr, .rd, .rdata, .pad_i, .pad, .evt,
    .cfg_pb3_reset, .cfg_xtal_en, .cfg_clkout_en, .ir_carrier, .inst_clk, .pwm_data, .bz_data);
  gp_pins pins (.mclk, .pad, .ext_en, .ext_val, .pad_i);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic test_done();
    if (err_total == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rdreg(input logic [AW-1:0] a, output logic [DW-1:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge mclk);
  endtask
  // Covers two sync stages, flag and request registers
  task automatic settle();
    repeat (6) @(posedge mclk);
    #1;
  endtask
  task automatic t_reset();
    chk("oe after reset", 12'h000, pad.oe);
    for (int i = 0; i < 18; i++) begin
      rdreg(i[AW-1:0], q);
      chk("reset reg", (i == 2) ? 12'h00f : (i == 3) ? 12'h0ff : 12'h000, {4'h0, q});
    end
    rdreg(5'h1f, q);
    chk("unmapped", 12'h000, {4'h0, q});
  endtask
  task automatic t_data_a();
    wreg(OFF_DIR_A, 8'h00);
    wreg(OFF_DATA_A, 8'h05);
    settle();
    chk("pa oe", 12'h00f, {8'h0, pad.oe[3:0]});
    chk("pa out", 12'h005, {8'h0, pad.out[3:0]});
    wreg(OFF_DIR_A, 8'h0f);
    ext_val[3:0] <= 4'ha;
    settle();
    rdreg(OFF_DATA_A, q);
    chk("pa pin read", 12'h00a, {4'h0, q});
    wreg(OFF_RD_TYPE_A, 8'h0f);
    rdreg(OFF_DATA_A, q);
    chk("pa latch read", 12'h005, {4'h0, q});
    wreg(OFF_RD_TYPE_A, 8'h00);
  endtask
  task automatic t_pulls();
    ext_en <= 12'h000;
    wreg(OFF_PULL_LOW, 8'hff);
    wreg(OFF_PULL_HIGH, 8'hff);
    settle();
    chk("pd", 12'h0ff, pad.pd);
    chk("pu", 12'hf70, pad.pu);
    rdreg(OFF_PULL_HIGH, q);
    chk("pu reg", 12'h0f7, {4'h0, q});
    rdreg(OFF_DATA_A, q);
    chk("pa pulled", 12'h000, {4'h0, q});
    wreg(OFF_DIR_A, 8'h00);
    wreg(OFF_DIR_B, 8'h00);
    settle();
    chk("pd out", 12'h000, pad.pd);
    chk("pu out", 12'h000, pad.pu);
    wreg(OFF_PULL_LOW, 8'h00);
    wreg(OFF_PULL_HIGH, 8'h00);
    ext_en <= 12'hfff;
  endtask
  task automatic t_odrain();
    wreg(OFF_DATA_B, 8'hff);
    settle();
    chk("pb oe pp", 12'h0f7, {4'h0, pad.oe[11:4]});
    wreg(OFF_OPEN_DRAIN, 8'hff);
    settle();
    chk("pb oe od hi", 12'h000, {4'h0, pad.oe[11:4]});
    wreg(OFF_DATA_B, 8'h00);
    settle();
    chk("pb oe od lo", 12'h0ff, {4'h0, pad.oe[11:4]});
    chk("pb out od lo", 12'h000, {4'h0, pad.out[11:4]});
    wreg(OFF_OPEN_DRAIN, 8'h00);
    wreg(OFF_DIR_B, 8'hff);
  endtask
  task automatic t_change();
    wreg(OFF_CHG_SEL, 8'h06);
    wreg(OFF_INT_EN, 8'h02);
    wreg(OFF_PWR_CTL1, 8'h80);
    ext_val[PB7] <= 1'b1;
    settle();
    rdreg(OFF_INT_FLAG, q);
    chk("unselected", 12'h000, {4'h0, q});
    ext_val[PB2] <= 1'b1;
    settle();
    rdreg(OFF_INT_FLAG, q);
    chk("chg flag", 12'h002, {4'h0, q});
    chk("int req", 12'h001, {11'h0, evt.int_req});
    wreg(OFF_INT_FLAG, 8'h00);
    settle();
    rdreg(OFF_INT_FLAG, q);
    chk("flag clear", 12'h000, {4'h0, q});
    wreg(OFF_PWR_CTL1, 8'h00);
    ext_val[PB1] <= 1'b1;
    settle();
    rdreg(OFF_INT_FLAG, q);
    chk("flag no gie", 12'h002, {4'h0, q});
    chk("req no gie", 12'h000, {11'h0, evt.int_req});
    wreg(OFF_INT_EN, 8'h00);
    wreg(OFF_PWR_CTL1, 8'h80);
    settle();
    chk("req no en", 12'h000, {11'h0, evt.int_req});
    wreg(OFF_INT_FLAG, 8'h00);
  endtask
  task automatic t_extint();
    wreg(OFF_PWR_CTL, 8'h40);
    wreg(OFF_CHG_SEL, 8'h01);
    ext_val[PB0] <= 1'b1;
    settle();
    rdreg(OFF_INT_FLAG, q);
    chk("pb0 rise", 12'h000, {4'h0, q});
    ext_val[PB0] <= 1'b0;
    settle();
    rdreg(OFF_INT_FLAG, q);
    chk("pb0 fall", 12'h004, {4'h0, q});
    wreg(OFF_INT_FLAG, 8'h00);
    wreg(OFF_PWR_CTL, 8'h00);
    ext_val[PB0] <= 1'b1;
    settle();
    rdreg(OFF_INT_FLAG, q);
    chk("pb0 chg", 12'h002, {4'h0, q});
    wreg(OFF_INT_FLAG, 8'h00);
    wreg(OFF_MISC, 8'h01);
    wreg(OFF_INT_EN, 8'h04);
    wreg(OFF_PWR_CTL, 8'h40);
    ext_val[PB0] <= 1'b0;
    settle();
    rdreg(OFF_INT_FLAG, q);
    chk("pb0 fall rise sel", 12'h000, {4'h0, q});
    ext_val[PB0] <= 1'b1;
    settle();
    rdreg(OFF_INT_FLAG, q);
    chk("pb0 rise sel", 12'h004, {4'h0, q});
    chk("ext req", 12'h001, {11'h0, evt.int_req});
    wreg(OFF_INT_FLAG, 8'h00);
    wreg(OFF_INT_EN, 8'h00);
    wreg(OFF_PWR_CTL, 8'h00);
    wreg(OFF_MISC, 8'h00);
    wreg(OFF_CHG_SEL, 8'h00);
  endtask
  task automatic t_freeze();
    ce <= 1'b0;
    wreg(OFF_PULL_LOW, 8'h0f);
    rdreg(OFF_DIR_A, q);
    ce <= 1'b1;
    chk("ce low read", 12'h005, {4'h0, q});
    rdreg(OFF_PULL_LOW, q);
    chk("ce low write", 12'h000, {4'h0, q});
  endtask
  task automatic t_alt();
    wreg(OFF_DATA_B, 8'h00);
    wreg(OFF_IR_CTL, 8'h01);
    wreg(OFF_T1_CTL1, 8'h80);
    wreg(OFF_BZ_CTL, 8'h80);
    cfg_clkout_en <= 1'b1;
    settle();
    chk("alt oe", 12'h0d2, {4'h0, pad.oe[11:4]});
    chk("alt out", 12'h0d2, {4'h0, pad.out[11:4]});
    {ir_carrier, inst_clk, pwm_data, bz_data} <= 4'h0;
    settle();
    chk("alt out lo", 12'h000, {4'h0, pad.out[11:4]});
    {ir_carrier, inst_clk, pwm_data, bz_data} <= 4'hf;
    cfg_xtal_en <= 1'b1;
    settle();
    chk("xtal oe", 12'h0c2, {4'h0, pad.oe[11:4]});
    wreg(OFF_IR_CTL, 8'h00);
    settle();
    chk("ir off oe", 12'h0c0, {4'h0, pad.oe[11:4]});
    cfg_pb3_reset <= 1'b1;
    ext_val[PB3] <= 1'b0;
    settle();
    chk("ext rst", 12'h001, {11'h0, evt.ext_rst});
    ext_val[PB3] <= 1'b1;
    settle();
    chk("ext rst off", 12'h000, {11'h0, evt.ext_rst});
    wreg(OFF_MISC, 8'h02);
    settle();
    chk("t0 ext", 12'h001, {11'h0, evt.t0_clk});
    wreg(OFF_MISC, 8'h06);
    settle();
    chk("t0 low clk", 12'h000, {11'h0, evt.t0_clk});
    wreg(OFF_MISC, 8'h08);
    settle();
    chk("t1 ext", 12'h001, {11'h0, evt.t1_clk});
  endtask
  initial begin
    {rstn, wr, rd, cfg_pb3_reset, cfg_xtal_en, cfg_clkout_en} = '0;
    {ir_carrier, inst_clk, pwm_data, bz_data, ce} = '1;
    addr = '0;
    wdata = '0;
    ext_en = '1;
    ext_val = '0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_data_a();
    t_freeze();
    t_pulls();
    t_odrain();
    t_change();
    t_extint();
    t_alt();
    test_done();
  end
endmodule
